// ---- hdl/pcg_top.sv ----
/*
 * Peripheral clock gating: six gating registers, a run clock
 * configuration register with the automatic gating select bit, fault
 * interrupt, classic Wishbone slave and per-unit clock enables.
 * Assumes one 100 MHz clock, synchronous active-high reset, and that
 * downstream clock gate cells are latch-based and glitch-free.
 */
// Our own choice: the Wishbone interface to the registers.
`timescale 1ns/10ps
`include "pcg_params.svh"

module pcg_top (
	input  wire logic                clk_i,
	input  wire logic                rst_i,
	input  wire logic                wb_cyc_i,
	input  wire logic                wb_stb_i,
	input  wire logic                wb_we_i,
	input  wire logic [11:0]         wb_adr_i,
	input  wire logic [3:0]          wb_sel_i,
	input  wire logic [31:0]         wb_dat_i,
	output logic      [31:0]         wb_dat_o,
	output logic                     wb_ack_o,
	output logic                     wb_err_o,
	input  wire pcg_pkg::pcg_mode_t  mode_i,
	input  wire logic                unit_acc_i,
	input  wire logic [3:0]          unit_idx_i,
	output logic                     unit_fault_o,
	output logic                     power_down_module_gate_o,
	output logic                     watchdog_gate_o,
	output logic                     comparator_1_gate_o,
	output logic                     comparator_0_gate_o,
	output logic      [3:0]          timer_gate_o,
	output logic                     two_wire_1_gate_o,
	output logic                     two_wire_0_gate_o,
	output logic                     sync_serial_1_gate_o,
	output logic                     sync_serial_0_gate_o,
	output logic      [2:0]          async_serial_gate_o,
	output logic                     irq_o
);
	import pcg_pkg::*;

	// ----------------------------------------------------------------
	// Register state
	// ----------------------------------------------------------------
	logic [31:0] run_gate_set0;
	logic [31:0] run_gate_set1;
	logic [31:0] sleep_gate_set0;
	logic [31:0] sleep_gate_set1;
	logic [31:0] deep_sleep_gate_set0;
	logic [31:0] deep_sleep_gate_set1;
	logic        auto_gating_select;
	logic [`PCG_IRQ_WIDTH-1:0] irq_stat;
	logic [`PCG_IRQ_WIDTH-1:0] irq_mask;
	pcg_bus_t    bus_st;

	// Next values from the decode process
	logic [31:0] next_run0;
	logic [31:0] next_run1;
	logic [31:0] next_sleep0;
	logic [31:0] next_sleep1;
	logic [31:0] next_deep0;
	logic [31:0] next_deep1;
	logic        next_auto;
	logic [`PCG_IRQ_WIDTH-1:0] next_stat;
	logic [`PCG_IRQ_WIDTH-1:0] next_mask;
	pcg_bus_t    next_bus_st;
	logic [31:0] next_dat;
	logic        next_ack;
	logic        next_err;
	logic        next_irq;

	// Mode stage outputs and decode helpers
	logic [31:0] act0;
	logic [31:0] act1;
	logic        fault;
	logic        bus_req;
	logic        wr_ok;
	logic        hit;
	pcg_units_t  units;

	// Byte-lane merge, masked to the writable bits of a register
	function automatic logic [31:0] lane_merge(
		input logic [31:0] old_v,
		input logic [31:0] new_v,
		input logic [3:0]  sel,
		input logic [31:0] wmask
	);
		logic [31:0] m;
		m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}} & wmask;
		// A lane left out by sel keeps its old byte
		lane_merge = (old_v & ~m) | (new_v & m);
	endfunction

	// ----------------------------------------------------------------
	// Sub-blocks
	// ----------------------------------------------------------------
	// The mode stage registers the chosen copy, so enables move on an edge only
	pcg_mode_select i_pcg_mode_select (
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.mode_i      (mode_i),
		.auto_gate_i (auto_gating_select),
		.run0_i      (run_gate_set0),
		.run1_i      (run_gate_set1),
		.sleep0_i    (sleep_gate_set0),
		.sleep1_i    (sleep_gate_set1),
		.deep0_i     (deep_sleep_gate_set0),
		.deep1_i     (deep_sleep_gate_set1),
		.act0_o      (act0),
		.act1_o      (act1)
	);

	// Unit index order: 0..2 async serial, 3..4 sync serial, 5..6 two-wire,
	// 7..10 timers, 11..12 comparators, 13 watchdog, 14 power-down module
	assign units = {act0[`PCG_BIT_HIB],
	                act0[`PCG_BIT_WDOG],
	                act1[`PCG_BIT_CMP1:`PCG_BIT_CMP0],
	                act1[`PCG_BIT_TMR3:`PCG_BIT_TMR0],
	                act1[`PCG_BIT_TW1],
	                act1[`PCG_BIT_TW0],
	                act1[`PCG_BIT_SS1:`PCG_BIT_SS0],
	                act1[`PCG_BIT_AS2:`PCG_BIT_AS0]};

	// Faults judge against the enables the units really see, not the raw registers
	pcg_unit_fault i_pcg_unit_fault (
		.clk_i      (clk_i),
		.rst_i      (rst_i),
		.acc_i      (unit_acc_i),
		.acc_unit_i (unit_idx_i),
		.en_i       (units),
		.fault_o    (fault)
	);

	// ----------------------------------------------------------------
	// Bus decode and register update
	// ----------------------------------------------------------------
	// Taken only while idle, so a strobe still held in the answer cycle is not taken twice
	assign bus_req = wb_cyc_i && wb_stb_i && (bus_st == PCG_BUS_IDLE);

	// One-cycle answer; unmapped addresses end with err and write nothing
	always_comb begin
		// Defaults hold every register and answer nothing
		next_run0   = run_gate_set0;
		next_run1   = run_gate_set1;
		next_sleep0 = sleep_gate_set0;
		next_sleep1 = sleep_gate_set1;
		next_deep0  = deep_sleep_gate_set0;
		next_deep1  = deep_sleep_gate_set1;
		next_auto   = auto_gating_select;
		next_mask   = irq_mask;
		next_stat   = irq_stat;
		next_dat    = 32'h0000_0000;
		next_bus_st = PCG_BUS_IDLE;
		hit         = 1'b1;
		wr_ok       = bus_req && wb_we_i;
		// Reserved bits never reach a register: the write mask stops them
		if (wb_adr_i == `PCG_OFF_RUN0) begin
			next_dat = run_gate_set0;
			if (wr_ok) begin
				next_run0 = lane_merge(run_gate_set0, wb_dat_i, wb_sel_i, `PCG_MASK_SET0);
			end
		end else if (wb_adr_i == `PCG_OFF_RUN1) begin
			next_dat = run_gate_set1;
			if (wr_ok) begin
				next_run1 = lane_merge(run_gate_set1, wb_dat_i, wb_sel_i, `PCG_MASK_SET1);
			end
		end else if (wb_adr_i == `PCG_OFF_SLEEP0) begin
			next_dat = sleep_gate_set0;
			if (wr_ok) begin
				next_sleep0 = lane_merge(sleep_gate_set0, wb_dat_i, wb_sel_i, `PCG_MASK_SET0);
			end
		end else if (wb_adr_i == `PCG_OFF_SLEEP1) begin
			next_dat = sleep_gate_set1;
			if (wr_ok) begin
				next_sleep1 = lane_merge(sleep_gate_set1, wb_dat_i, wb_sel_i, `PCG_MASK_SET1);
			end
		end else if (wb_adr_i == `PCG_OFF_DEEP0) begin
			next_dat = deep_sleep_gate_set0;
			if (wr_ok) begin
				next_deep0 = lane_merge(deep_sleep_gate_set0, wb_dat_i, wb_sel_i, `PCG_MASK_SET0);
			end
		end else if (wb_adr_i == `PCG_OFF_DEEP1) begin
			next_dat = deep_sleep_gate_set1;
			if (wr_ok) begin
				next_deep1 = lane_merge(deep_sleep_gate_set1, wb_dat_i, wb_sel_i, `PCG_MASK_SET1);
			end
		end else if (wb_adr_i == `PCG_OFF_RUNCFG) begin
			next_dat[`PCG_BIT_AUTO_GATE] = auto_gating_select;
			if (wr_ok && wb_sel_i[3]) begin
				next_auto = wb_dat_i[`PCG_BIT_AUTO_GATE];
			end
		end else if (wb_adr_i == `PCG_OFF_IRQ_STAT) begin
			next_dat[`PCG_IRQ_WIDTH-1:0] = irq_stat;
			if (wr_ok && wb_sel_i[0]) begin
				next_stat = irq_stat & ~wb_dat_i[`PCG_IRQ_WIDTH-1:0];
			end
		end else if (wb_adr_i == `PCG_OFF_IRQ_MASK) begin
			next_dat[`PCG_IRQ_WIDTH-1:0] = irq_mask;
			if (wr_ok && wb_sel_i[0]) begin
				next_mask = wb_dat_i[`PCG_IRQ_WIDTH-1:0];
			end
		end else begin
			hit = 1'b0;
		end
		// A fault in the clearing cycle still sets the flag
		if (fault) begin
			next_stat[`PCG_IRQ_FAULT] = 1'b1;
		end
		// One answer per request, in the cycle after the taking edge
		if (bus_req) begin
			next_bus_st = PCG_BUS_ACK;
		end
		next_ack = bus_req && hit;
		next_err = bus_req && !hit;
		// Data stands only in the answer cycle so a stale word never leaks
		if (!bus_req) begin
			next_dat = 32'h0000_0000;
		end
		// Level interrupt from the values the flops are about to hold
		next_irq = |(next_stat & next_mask);
	end

	// Registers only; gate outputs follow two cycles after the write, through the mode stage and the output flops
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			run_gate_set0        <= `PCG_RST_GATE;
			run_gate_set1        <= `PCG_RST_GATE;
			sleep_gate_set0      <= `PCG_RST_GATE;
			sleep_gate_set1      <= `PCG_RST_GATE;
			deep_sleep_gate_set0 <= `PCG_RST_GATE;
			deep_sleep_gate_set1 <= `PCG_RST_GATE;
			auto_gating_select   <= 1'b0;
			irq_stat             <= '0;
			irq_mask             <= '0;
			bus_st               <= PCG_BUS_IDLE;
			wb_dat_o             <= 32'h0000_0000;
			wb_ack_o             <= 1'b0;
			wb_err_o             <= 1'b0;
			irq_o                <= 1'b0;
		end else begin
			run_gate_set0        <= next_run0;
			run_gate_set1        <= next_run1;
			sleep_gate_set0      <= next_sleep0;
			sleep_gate_set1      <= next_sleep1;
			deep_sleep_gate_set0 <= next_deep0;
			deep_sleep_gate_set1 <= next_deep1;
			auto_gating_select   <= next_auto;
			irq_stat             <= next_stat;
			irq_mask             <= next_mask;
			bus_st               <= next_bus_st;
			wb_dat_o             <= next_dat;
			wb_ack_o             <= next_ack;
			wb_err_o             <= next_err;
			irq_o                <= next_irq;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Enables drive latch-based gate cells, so no glitch reaches a unit clock
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			power_down_module_gate_o <= 1'b0;
			watchdog_gate_o          <= 1'b0;
			comparator_1_gate_o      <= 1'b0;
			comparator_0_gate_o      <= 1'b0;
			timer_gate_o             <= 4'h0;
			two_wire_1_gate_o        <= 1'b0;
			two_wire_0_gate_o        <= 1'b0;
			sync_serial_1_gate_o     <= 1'b0;
			sync_serial_0_gate_o     <= 1'b0;
			async_serial_gate_o      <= 3'h0;
			unit_fault_o             <= 1'b0;
		end else begin
			power_down_module_gate_o <= act0[`PCG_BIT_HIB];
			watchdog_gate_o          <= act0[`PCG_BIT_WDOG];
			comparator_1_gate_o      <= act1[`PCG_BIT_CMP1];
			comparator_0_gate_o      <= act1[`PCG_BIT_CMP0];
			timer_gate_o             <= act1[`PCG_BIT_TMR3:`PCG_BIT_TMR0];
			two_wire_1_gate_o        <= act1[`PCG_BIT_TW1];
			two_wire_0_gate_o        <= act1[`PCG_BIT_TW0];
			sync_serial_1_gate_o     <= act1[`PCG_BIT_SS1];
			sync_serial_0_gate_o     <= act1[`PCG_BIT_SS0];
			async_serial_gate_o      <= act1[`PCG_BIT_AS2:`PCG_BIT_AS0];
			unit_fault_o             <= fault;
		end
	end
endmodule // pcg_top

// ---- shared/pcg_params.svh ----
/*
 * Register offsets, field positions, masks and reset values of the
 * peripheral clock gating block.
 * Assumes inclusion by bare name from the package and the design files.
 */
`ifndef PCG_PARAMS_SVH
`define PCG_PARAMS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define PCG_OFF_RUN0        12'h100
`define PCG_OFF_RUN1        12'h104
`define PCG_OFF_SLEEP0      12'h110
`define PCG_OFF_SLEEP1      12'h114
`define PCG_OFF_DEEP0       12'h120
`define PCG_OFF_DEEP1       12'h124
`define PCG_OFF_RUNCFG      12'h060
`define PCG_OFF_IRQ_STAT    12'h200
`define PCG_OFF_IRQ_MASK    12'h204

// ----------------------------------------------------------------
// Writable-bit masks and reset values
// ----------------------------------------------------------------
`define PCG_MASK_SET0       32'h0000_0048
`define PCG_MASK_SET1       32'h030f_5037
`define PCG_RST_GATE        32'h0000_0000
`define PCG_RST_SET0_W      7'h00
`define PCG_RST_SET1_W      26'h000_0000

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PCG_BIT_HIB         6
`define PCG_BIT_WDOG        3
`define PCG_BIT_CMP1        25
`define PCG_BIT_CMP0        24
`define PCG_BIT_TMR3        19
`define PCG_BIT_TMR0        16
`define PCG_BIT_TW1         14
`define PCG_BIT_TW0         12
`define PCG_BIT_SS1         5
`define PCG_BIT_SS0         4
`define PCG_BIT_AS2         2
`define PCG_BIT_AS0         0
`define PCG_BIT_AUTO_GATE   27
`define PCG_IRQ_FAULT       0
`define PCG_IRQ_WIDTH       1
`define PCG_UNITS           15

`endif

// ---- shared/pcg_pkg.sv ----
/*
 * Types shared by the peripheral clock gating design.
 * Assumes pcg_params.svh is on the include path.
 */
`include "pcg_params.svh"

package pcg_pkg;
	// Power mode requested by the core
	typedef enum logic [1:0] {
		PCG_MODE_RUN   = 2'b00,
		PCG_MODE_SLEEP = 2'b01,
		PCG_MODE_DEEP  = 2'b10
	} pcg_mode_t;

	// Bus slave state
	typedef enum logic [0:0] {
		PCG_BUS_IDLE = 1'b0,
		PCG_BUS_ACK  = 1'b1
	} pcg_bus_t;

	typedef logic [`PCG_UNITS-1:0] pcg_units_t;
endpackage

// ---- hdl/pcg_mode_select.sv ----
/*
 * Chooses the active gating copy from the power mode and the
 * automatic gating select bit, and registers the resulting enables.
 * Assumes a single clock and synchronous active-high reset.
 */
`timescale 1ns/10ps
`include "pcg_params.svh"

module pcg_mode_select (
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	input  wire pcg_pkg::pcg_mode_t mode_i,
	input  wire logic              auto_gate_i,
	input  wire logic [31:0]       run0_i,
	input  wire logic [31:0]       run1_i,
	input  wire logic [31:0]       sleep0_i,
	input  wire logic [31:0]       sleep1_i,
	input  wire logic [31:0]       deep0_i,
	input  wire logic [31:0]       deep1_i,
	output logic      [31:0]       act0_o,
	output logic      [31:0]       act1_o
);
	import pcg_pkg::*;

	logic [31:0] next_act0;
	logic [31:0] next_act1;

	// ----------------------------------------------------------------
	// Copy selection
	// ----------------------------------------------------------------
	// Without auto gating the run copy stays in force in every mode
	always_comb begin
		next_act0 = run0_i;
		next_act1 = run1_i;
		if (auto_gate_i) begin
			case (mode_i)
				PCG_MODE_SLEEP: begin
					next_act0 = sleep0_i;
					next_act1 = sleep1_i;
				end
				PCG_MODE_DEEP: begin
					next_act0 = deep0_i;
					next_act1 = deep1_i;
				end
				default: begin
					next_act0 = run0_i;
					next_act1 = run1_i;
				end
			endcase
		end
	end

	// Registered so the enables only change on a clock edge
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			act0_o <= `PCG_RST_GATE;
			act1_o <= `PCG_RST_GATE;
		end else begin
			act0_o <= next_act0 & `PCG_MASK_SET0;
			act1_o <= next_act1 & `PCG_MASK_SET1;
		end
	end
endmodule // pcg_mode_select

// ---- hdl/pcg_unit_fault.sv ----
/*
 * Bus fault checker for accesses to the gated units.
 * Assumes the unit fabric raises a one-cycle access pulse with a unit index.
 */
`timescale 1ns/10ps
`include "pcg_params.svh"

module pcg_unit_fault (
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	input  wire logic              acc_i,
	input  wire logic [3:0]        acc_unit_i,
	input  wire pcg_pkg::pcg_units_t en_i,
	output logic                   fault_o
);
	import pcg_pkg::*;

	logic next_fault;

	// ----------------------------------------------------------------
	// Fault detection
	// ----------------------------------------------------------------
	// Indices beyond the unit list are not ours to fault
	always_comb begin
		next_fault = 1'b0;
		if (acc_i && (acc_unit_i < 4'(`PCG_UNITS))) begin
			next_fault = ~en_i[acc_unit_i];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fault_o <= 1'b0;
		end else begin
			fault_o <= next_fault;
		end
	end
endmodule // pcg_unit_fault

// ---- tb/pcg_assertions.sv ----
/*
 * Port checker for the clock gating block.
 * Assumes it is bound to pcg_top and sees a single clock domain.
 */
`timescale 1ns/10ps

module pcg_checker (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [11:0] wb_adr_i,
	input  wire logic [31:0] wb_dat_o,
	input  wire logic        wb_ack_o,
	input  wire logic        wb_err_o,
	input  wire logic        unit_acc_i,
	input  wire logic [3:0]  unit_idx_i,
	input  wire logic        unit_fault_o,
	input  wire logic        watchdog_gate_o,
	input  wire logic [3:0]  timer_gate_o,
	input  wire logic        irq_o
);
	// ----
	// Helpers
	// ----
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic mapped, rd_set1, rd_set0, acc_real, acc_wd;
	// Decodes kept here so that $past only ever sees plain signals
	assign mapped = wb_adr_i inside {12'h060, 12'h100, 12'h104, 12'h110, 12'h114, 12'h120, 12'h124, 12'h200, 12'h204};
	assign rd_set1 = !wb_we_i && wb_adr_i == 12'h104;
	assign rd_set0 = !wb_we_i && wb_adr_i inside {12'h100, 12'h110, 12'h120};
	assign acc_real = unit_acc_i && unit_idx_i != 4'hf;
	assign acc_wd = unit_acc_i && unit_idx_i == 4'd13;
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
	endsequence
	sequence s_answer;
		(wb_ack_o ^ wb_err_o) ##1 !(wb_ack_o || wb_err_o);
	endsequence
	// One cycle after the access the gate output shows the enable the fault stage used
	sequence s_wd_off;
		acc_wd ##1 !watchdog_gate_o;
	endsequence
	sequence s_wd_on;
		acc_wd ##1 watchdog_gate_o;
	endsequence
	// ----
	// Properties
	// ----
	a_bus_answer: assert property (s_req |=> s_answer) else $error("bus answer missing or too long");
	a_err_unmapped: assert property (wb_err_o |-> !$past(mapped)) else $error("error on mapped offset");
	a_ack_mapped: assert property (wb_ack_o |-> $past(mapped)) else $error("ack on unmapped offset");
	a_idle_data: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("read data outside ack");
	a_set1_reserved: assert property (wb_ack_o && $past(rd_set1) |-> (wb_dat_o & ~32'h030f_5037) == 32'h0)
		else $error("set1 reserved bit reads one");
	a_set0_reserved: assert property (wb_ack_o && $past(rd_set0) |-> (wb_dat_o & ~32'h0000_0048) == 32'h0)
		else $error("set0 reserved bit reads one");
	a_fault_cause: assert property (unit_fault_o |-> $past(acc_real, 2) || $past(acc_real, 3))
		else $error("fault without unit access");
	a_fault_wdog: assert property (s_wd_off |=> unit_fault_o) else $error("no fault for unclocked watchdog");
	a_no_fault_on: assert property (s_wd_on |=> !unit_fault_o) else $error("fault for clocked watchdog");
	a_reset_clear: assert property ($fell(rst_i) |-> timer_gate_o == 4'h0 && !watchdog_gate_o && !irq_o && !unit_fault_o)
		else $error("outputs not cleared by reset");
endmodule // pcg_checker

// ---- tb/pcg_top_tb_top.sv ----
/*
 * Self-checking bench: register map, gate outputs, unit fault, interrupt, power modes.
 * Assumes the design files and pcg_assertions.sv are compiled before it.
 */
`timescale 1ns/10ps

module pcg_top_tb_top;
	import pcg_pkg::*;
	logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, acc = 1'b0;
	logic [11:0] adr = 12'h0;
	logic [3:0]  sel = 4'h0, idx = 4'h0, tmr;
	logic [31:0] wdat = 32'h0, dat_o, q;
	logic        ack, err, fault, pdm, wdg, c1, c0, tw1, tw0, ss1, ss0, irq, e;
	logic [2:0]  asg;
	logic [14:0] ev;
	pcg_mode_t   mode = PCG_MODE_RUN;
	wire  [14:0] gv = {pdm, wdg, c1, c0, tmr, tw1, tw0, ss1, ss0, asg};
	int          err_total = 0, n_compared = 0;
	logic [11:0] regs [9] = '{12'h060, 12'h100, 12'h104, 12'h110, 12'h114, 12'h120, 12'h124, 12'h200, 12'h204};

	pcg_top i_pcg_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .wb_err_o(err),
		.mode_i(mode), .unit_acc_i(acc), .unit_idx_i(idx), .unit_fault_o(fault),
		.power_down_module_gate_o(pdm), .watchdog_gate_o(wdg), .comparator_1_gate_o(c1),
		.comparator_0_gate_o(c0), .timer_gate_o(tmr), .two_wire_1_gate_o(tw1), .two_wire_0_gate_o(tw0),
		.sync_serial_1_gate_o(ss1), .sync_serial_0_gate_o(ss0), .async_serial_gate_o(asg), .irq_o(irq));

	// ----
	// Tasks
	// ----
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// One classic cycle; the idle edge at the end keeps drivers from double assignment
	task automatic wb(input logic [11:0] a, input logic w, input logic [31:0] d, input logic [3:0] s);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= s;
		do @(posedge clk_i); while (ack !== 1'b1 && err !== 1'b1);
		q = dat_o;
		e = err;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		wb(a, 1'b1, d, 4'hf);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic exp_e);
		wb(a, 1'b0, 32'h0, 4'hf);
		chk(q, exp);
		chk({31'h0, e}, {31'h0, exp_e});
	endtask
	// Gates and mode lag the register by two edges, so three are allowed
	task automatic gates(input logic [14:0] exp);
		repeat (3) @(posedge clk_i);
		chk({17'h0, gv}, {17'h0, exp});
	endtask
	// One access pulse, then count fault pulses seen in the following cycles
	task automatic poke(input logic [3:0] u, input logic [31:0] n_exp);
		logic [31:0] n;
		n = 32'h0;
		acc <= 1'b1;
		idx <= u;
		@(posedge clk_i);
		acc <= 1'b0;
		repeat (5) begin
			@(posedge clk_i);
			if (fault !== 1'b0) n++;
		end
		chk(n, n_exp);
	endtask
	function automatic logic [14:0] eg(input logic [31:0] s0, input logic [31:0] s1);
		return {s0[6], s0[3], s1[25], s1[24], s1[19:16], s1[14], s1[12], s1[5], s1[4], s1[2:0]};
	endfunction
	task automatic stop_test;
		$display("compared %0d, mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// ----
	// Clock, watchdog, tests
	// ----
	initial begin
		forever #5 clk_i = ~clk_i;
	end
	// Whole run needs about 3500 cycles; a hang is cut well beyond that
	initial begin
		repeat (20000) @(posedge clk_i);
		err_total++;
		stop_test();
	end
	initial begin
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		for (int i = 0; i < 9; i++) rd(regs[i], 32'h0, 1'b0);
		gates(15'h0);
		wr(12'h104, 32'hffff_ffff);
		rd(12'h104, 32'h030f_5037, 1'b0);
		for (int i = 1; i < 6; i += 2) wr(regs[i], 32'hffff_ffff);
		for (int i = 1; i < 6; i += 2) rd(regs[i], 32'h0000_0048, 1'b0);
		wr(12'h108, 32'hffff_ffff);
		chk({31'h0, e}, 32'h1);
		rd(12'h108, 32'h0, 1'b1);
		wr(12'h104, 32'h0);
		wb(12'h104, 1'b1, 32'hffff_ffff, 4'b0100);
		rd(12'h104, 32'h000f_0000, 1'b0);
		// Walk a one through every bit of both run copies, reserved places too
		for (int i = 0; i < 32; i++) begin
			wr(12'h100, 32'h1 << i);
			wr(12'h104, 32'h1 << i);
			ev = eg(32'h1 << i, 32'h1 << i);
			gates(ev);
			// Only the unit behind the lit bit may answer without a fault
			for (int u = 0; u < 15; u++) poke(u[3:0], {31'h0, ~ev[u]});
		end
		wr(12'h100, 32'h0);
		wr(12'h104, 32'h0);
		repeat (3) @(posedge clk_i);
		for (int i = 0; i < 15; i++) poke(i[3:0], 32'h1);
		poke(4'hf, 32'h0);
		rd(12'h200, 32'h1, 1'b0);
		chk({31'h0, irq}, 32'h0);
		wr(12'h204, 32'h1);
		gates(15'h0);
		chk({31'h0, irq}, 32'h1);
		wr(12'h200, 32'h1);
		gates(15'h0);
		chk({31'h0, irq}, 32'h0);
		rd(12'h200, 32'h0, 1'b0);
		wr(12'h100, 32'hffff_ffff);
		wr(12'h104, 32'hffff_ffff);
		gates(15'h7fff);
		for (int i = 0; i < 15; i++) poke(i[3:0], 32'h0);
		// Low-power copies: ignored until the automatic gating select bit is set
		wr(12'h100, 32'h0);
		wr(12'h104, 32'h0);
		wr(12'h114, 32'h1);
		wr(12'h120, 32'h8);
		wr(12'h124, 32'h0100_0000);
		mode <= PCG_MODE_SLEEP;
		gates(15'h0);
		wr(12'h060, 32'h0800_0000);
		rd(12'h060, 32'h0800_0000, 1'b0);
		// Sleep set0 still holds both writable bits from the map test
		gates(15'h6001);
		mode <= PCG_MODE_DEEP;
		gates(15'h2800);
		mode <= pcg_mode_t'(2'b11);
		gates(15'h0);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		mode <= PCG_MODE_SLEEP;
		rd(12'h114, 32'h0, 1'b0);
		rd(12'h060, 32'h0, 1'b0);
		gates(15'h0);
		stop_test();
	end
endmodule // pcg_top_tb_top

bind pcg_top pcg_checker i_pcg_checker (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
	.unit_acc_i(unit_acc_i), .unit_idx_i(unit_idx_i), .unit_fault_o(unit_fault_o),
	.watchdog_gate_o(watchdog_gate_o), .timer_gate_o(timer_gate_o), .irq_o(irq_o));
